// ===== hsq_homing.sv
// Origin-return sequencer for switch-only homing methods 24, 25 and 26.
//
// Function
// - Codes fifteen and sixteen have no homing behaviour.
// - Switch-only methods never wait for index pulse.
// - Branch chosen from decel point and limit.
// - M24 no decel: fast, rev, fwd, stop.
// - M24 decel valid: rev low, fwd low, stop.
// - M24 limit first: reverse fast, then as before.
// - M25 no decel: fast, fwd, rev, stop.
// - M25 decel valid: fwd low, rev low, stop.
// - M25 limit first: reverse fast, then as before.
// - M26 no decel: fast, fwd low, stop falling.
// - M26 decel valid: fwd low, stop falling.
`timescale 1ns/1ps

module hsq_homing (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce,
  input  wire logic                    i_start,
  input  wire logic                    i_abort,
  input  wire logic [hsq_pkg::METHOD_W-1:0] i_method,
  input  wire hsq_pkg::hsq_sw_t        i_sw,
  output hsq_pkg::hsq_cmd_t            o_cmd,
  output logic                         o_busy,
  output logic                         o_done,
  output logic                         o_fault
);

  // ----------------------------------------------------------------
  // Method decoding
  // ----------------------------------------------------------------
  function automatic logic is_reserved(input logic [hsq_pkg::METHOD_W-1:0] m);
    is_reserved = (m == hsq_pkg::M_RSV_LO) || (m == hsq_pkg::M_RSV_HI);
  endfunction

  function automatic logic is_supported(input logic [hsq_pkg::METHOD_W-1:0] m);
    is_supported = !is_reserved(m) &&
                   ((m == hsq_pkg::M_24) || (m == hsq_pkg::M_25) || (m == hsq_pkg::M_26));
  endfunction

  // Direction of the low-speed leg taken after the first origin edge.
  function automatic hsq_pkg::hsq_cmd_t low_a(input logic [hsq_pkg::METHOD_W-1:0] m);
    low_a = (m == hsq_pkg::M_24) ? hsq_pkg::CMD_REV_LOW : hsq_pkg::CMD_FWD_LOW;
  endfunction

  // Direction of the low-speed leg taken after the origin falling edge.
  function automatic hsq_pkg::hsq_cmd_t low_b(input logic [hsq_pkg::METHOD_W-1:0] m);
    low_b = (m == hsq_pkg::M_25) ? hsq_pkg::CMD_REV_LOW : hsq_pkg::CMD_FWD_LOW;
  endfunction

  function automatic logic stop_on_fall(input logic [hsq_pkg::METHOD_W-1:0] m);
    stop_on_fall = (m == hsq_pkg::M_26);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hsq_pkg::hsq_state_t              state;
  hsq_pkg::hsq_state_t              next_state;
  hsq_pkg::hsq_cmd_t                cmd;
  hsq_pkg::hsq_cmd_t                next_cmd;
  logic [hsq_pkg::METHOD_W-1:0]     method;
  logic [hsq_pkg::METHOD_W-1:0]     next_method;
  logic                             done;
  logic                             next_done;
  logic                             fault;
  logic                             next_fault;
  logic                             org_q;
  logic                             next_org_q;
  logic                             lim_q;
  logic                             next_lim_q;
  logic                             org_rise;
  logic                             org_fall;
  logic                             lim_rise;
  logic                             final_edge;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  assign next_org_q = i_sw.origin;
  assign next_lim_q = i_sw.fwd_limit;
  assign org_rise   = i_sw.origin && !org_q;
  assign org_fall   = !i_sw.origin && org_q;
  assign lim_rise   = i_sw.fwd_limit && !lim_q;
  // The origin edge alone ends the sequence; no index pulse is awaited.
  assign final_edge = stop_on_fall(method) ? org_fall : org_rise;

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state  = state;
    next_cmd    = cmd;
    next_method = method;
    next_done   = done;
    next_fault  = fault;
    case (state)
      hsq_pkg::S_IDLE: begin
        if (i_start) begin
          next_done  = 1'b0;
          next_fault = 1'b0;
          if (is_supported(i_method)) begin
            next_method = i_method;
            if (i_sw.decel_ok) begin
              // Valid deceleration point starts on the first low leg.
              next_state = hsq_pkg::S_LOW_A;
              next_cmd   = low_a(i_method);
            end else begin
              next_state = hsq_pkg::S_FAST;
              next_cmd   = hsq_pkg::CMD_FWD_HIGH;
            end
          end else begin
            // Reserved and unimplemented codes are refused.
            next_fault = 1'b1;
          end
        end
      end
      hsq_pkg::S_FAST: begin
        if (org_rise) begin
          next_state = hsq_pkg::S_LOW_A;
          next_cmd   = low_a(method);
        end else if (lim_rise) begin
          next_state = hsq_pkg::S_RETRACT;
          next_cmd   = hsq_pkg::CMD_REV_HIGH;
        end
      end
      hsq_pkg::S_RETRACT: begin
        if (org_rise) begin
          next_state = hsq_pkg::S_LOW_A;
          next_cmd   = low_a(method);
        end
      end
      hsq_pkg::S_LOW_A: begin
        if (org_fall) begin
          next_state = hsq_pkg::S_LOW_B;
          next_cmd   = low_b(method);
        end
      end
      hsq_pkg::S_LOW_B: begin
        if (final_edge) begin
          next_state = hsq_pkg::S_IDLE;
          next_cmd   = hsq_pkg::CMD_STOP;
          next_done  = 1'b1;
        end
      end
      default: begin
        next_state = hsq_pkg::S_IDLE;
        next_cmd   = hsq_pkg::CMD_STOP;
      end
    endcase
    if (i_abort && (state != hsq_pkg::S_IDLE)) begin
      next_state = hsq_pkg::S_IDLE;
      next_cmd   = hsq_pkg::CMD_STOP;
      next_done  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state  <= hsq_pkg::S_IDLE;
      cmd    <= hsq_pkg::CMD_STOP;
      method <= '0;
      done   <= 1'b0;
      fault  <= 1'b0;
      org_q  <= 1'b0;
      lim_q  <= 1'b0;
    end else if (i_ce) begin
      state  <= next_state;
      cmd    <= next_cmd;
      method <= next_method;
      done   <= next_done;
      fault  <= next_fault;
      org_q  <= next_org_q;
      lim_q  <= next_lim_q;
    end
  end

  assign o_cmd   = cmd;
  assign o_busy  = (state != hsq_pkg::S_IDLE);
  assign o_done  = done;
  assign o_fault = fault;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  a_reserved_refused: assert property (
    (i_ce && state == hsq_pkg::S_IDLE && i_start && is_reserved(i_method))
    |=> (state == hsq_pkg::S_IDLE) && o_fault && (o_cmd == hsq_pkg::CMD_STOP))
    else $error("Reserved method started a motion.");

  a_done_origin_edge: assert property (
    $rose(o_done) |-> ($past(state) == hsq_pkg::S_LOW_B) && $past(final_edge))
    else $error("Homing finished without an origin edge.");

  a_branch_decel: assert property (
    (i_ce && state == hsq_pkg::S_IDLE && i_start && is_supported(i_method) && i_sw.decel_ok)
    |=> (state == hsq_pkg::S_LOW_A) && o_cmd.run && !o_cmd.high)
    else $error("Valid deceleration point did not start at low speed.");

  a_branch_fast: assert property (
    (i_ce && state == hsq_pkg::S_IDLE && i_start && is_supported(i_method) && !i_sw.decel_ok)
    |=> (state == hsq_pkg::S_FAST) && (o_cmd == hsq_pkg::CMD_FWD_HIGH))
    else $error("Invalid deceleration point did not start forward fast.");

  a_m24_first_rise: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_FAST && org_rise && method == hsq_pkg::M_24)
    |=> (o_cmd == hsq_pkg::CMD_REV_LOW))
    else $error("Method 24 did not reverse slowly on origin rise.");

  a_m24_fall_fwd: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_LOW_A && org_fall && method == hsq_pkg::M_24)
    |=> (o_cmd == hsq_pkg::CMD_FWD_LOW) && (state == hsq_pkg::S_LOW_B))
    else $error("Method 24 did not go forward slowly on origin fall.");

  a_limit_retract: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_FAST && lim_rise && !org_rise)
    |=> (o_cmd == hsq_pkg::CMD_REV_HIGH) && (state == hsq_pkg::S_RETRACT))
    else $error("Forward limit did not reverse at high speed.");

  a_m25_first_rise: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_FAST && org_rise && method == hsq_pkg::M_25)
    |=> (o_cmd == hsq_pkg::CMD_FWD_LOW))
    else $error("Method 25 did not go forward slowly on origin rise.");

  a_m25_stop_rise: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_LOW_B && org_rise && method == hsq_pkg::M_25)
    |=> (state == hsq_pkg::S_IDLE) && o_done && (o_cmd == hsq_pkg::CMD_STOP))
    else $error("Method 25 did not stop on origin rise.");

  a_retract_rise: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_RETRACT && org_rise)
    |=> (state == hsq_pkg::S_LOW_A) && (o_cmd == low_a(method)))
    else $error("Retract leg did not slow down on origin rise.");

  a_m26_stop_fall: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_LOW_B && method == hsq_pkg::M_26)
    |=> (o_done == $past(org_fall)) && (o_busy != $past(org_fall)))
    else $error("Method 26 stop does not match the origin fall.");

  a_m26_keep_fwd: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_LOW_A && org_fall && method == hsq_pkg::M_26)
    |=> (o_cmd == hsq_pkg::CMD_FWD_LOW) && !o_done)
    else $error("Method 26 did not keep forward low speed.");

  a_step_holds: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_LOW_A && !org_fall)
    |=> $stable(state) && $stable(o_cmd))
    else $error("Step advanced without its awaited edge.");

  a_done_idle: assert property (
    o_done |-> (o_cmd == hsq_pkg::CMD_STOP) && (state == hsq_pkg::S_IDLE))
    else $error("Done flagged while motion is commanded.");

  a_m24_retract_rev: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_RETRACT && org_rise && method == hsq_pkg::M_24)
    |=> (state == hsq_pkg::S_LOW_A) && (o_cmd == hsq_pkg::CMD_REV_LOW))
    else $error("Method 24 retract did not slow to reverse low speed.");

  a_m25_retract_fwd: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_RETRACT && org_rise && method == hsq_pkg::M_25)
    |=> (state == hsq_pkg::S_LOW_A) && (o_cmd == hsq_pkg::CMD_FWD_LOW))
    else $error("Method 25 retract did not slow to forward low speed.");

  a_m24_stop_rise: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_LOW_B && org_rise && method == hsq_pkg::M_24)
    |=> (state == hsq_pkg::S_IDLE) && o_done && (o_cmd == hsq_pkg::CMD_STOP))
    else $error("Method 24 did not stop on origin rise.");

  a_fast_holds: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_FAST && !org_rise && !lim_rise)
    |=> $stable(state) && $stable(o_cmd))
    else $error("Fast leg changed without an origin or limit edge.");

  a_retract_holds: assert property (
    (i_ce && !i_abort && state == hsq_pkg::S_RETRACT && !org_rise)
    |=> $stable(state) && $stable(o_cmd))
    else $error("Retract leg changed without an origin rise.");

  a_fault_still: assert property (
    o_fault |-> !o_busy && (o_cmd == hsq_pkg::CMD_STOP))
    else $error("Fault flagged while motion is commanded.");

  a_abort_stop: assert property (
    (i_ce && i_abort && state != hsq_pkg::S_IDLE)
    |=> (state == hsq_pkg::S_IDLE) && !o_done && (o_cmd == hsq_pkg::CMD_STOP))
    else $error("Abort did not stop the sequence.");

  a_freeze_hold: assert property (
    !i_ce |=> $stable(state) && $stable(o_cmd) && $stable(o_done) && $stable(o_fault))
    else $error("State moved while the clock enable was low.");

endmodule

// ===== hsq_homing_tb.sv
// Self-checking testbench for the homing sequencer.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end

module hsq_homing_tb;
  logic                       i_sys_clk = 1'b0;
  logic                       i_rst     = 1'b1;
  logic                       i_start   = 1'b0;
  logic                       i_abort   = 1'b0;
  logic [7:0]                 i_method  = 8'h00;
  logic                       load      = 1'b1;
  logic [15:0]                pos       = 16'h0000;
  logic                       decel     = 1'b0;
  logic                       ce        = 1'b1;
  hsq_pkg::hsq_sw_t           sw;
  hsq_pkg::hsq_cmd_t          o_cmd;
  logic                       o_busy;
  logic                       o_done;
  logic                       o_fault;
  int                         fails     = 0;
  int                         cmp_count = 0;

  always #12.5 i_sys_clk = ~i_sys_clk;

  hsq_homing u_dut (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_ce      (ce),
    .i_start   (i_start),
    .i_abort   (i_abort),
    .i_method  (i_method),
    .i_sw      (sw),
    .o_cmd     (o_cmd),
    .o_busy    (o_busy),
    .o_done    (o_done),
    .o_fault   (o_fault)
  );

  hsq_motion_model u_axis (
    .i_sys_clk  (i_sys_clk),
    .i_cmd      (o_cmd),
    .i_load     (load),
    .i_pos      (pos),
    .i_decel_ok (decel),
    .o_sw       (sw)
  );

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic launch(input logic [7:0] m, input logic [15:0] p, input logic d);
    @(posedge i_sys_clk);
    load <= 1'b1;
    pos <= p;
    decel <= d;
    @(posedge i_sys_clk);
    load <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_start <= 1'b1;
    i_method <= m;
    @(posedge i_sys_clk);
    i_start <= 1'b0;
  endtask

  // Runs one homing and compares the series of distinct commands seen.
  task automatic home(input logic [7:0] m, input logic [15:0] p, input logic d,
                      input logic [2:0] exp[$], input logic inj, input string nm);
    logic [2:0] seen[$];
    logic [2:0] last;
    int         n;
    logic       fin;
    launch(m, p, d);
    last = 3'h0;
    n    = 0;
    fin  = 1'b0;
    // Done is judged at the falling edge, so the flag left by the previous run
    // cannot end the loop in the time step in which the start is taken.
    while (!fin) begin
      @(negedge i_sys_clk);
      n++;
      if (o_cmd !== last) begin
        seen.push_back(o_cmd);
        last = o_cmd;
      end
      fin = (o_done === 1'b1) || (n >= 3000);
      @(posedge i_sys_clk);
      i_start  <= inj && (n == 5);
      i_method <= inj ? hsq_pkg::M_26 : m;
    end
    `CHK({nm, " steps"}, exp.size(), seen.size())
    foreach (exp[i]) if (i < seen.size()) `CHK({nm, " cmd"}, exp[i], seen[i])
    repeat (4) @(negedge i_sys_clk);
    `CHK({nm, " done"}, 1'b1, o_done)
    `CHK({nm, " busy"}, 1'b0, o_busy)
    `CHK({nm, " stop"}, 3'h0, o_cmd)
    $display("test %s finished", nm);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_m24;
    home(hsq_pkg::M_24, 16'h0000, 1'b0, '{3'h7, 3'h4, 3'h6, 3'h0}, 1'b0, "m24_1");
    home(hsq_pkg::M_24, 16'h006E, 1'b1, '{3'h4, 3'h6, 3'h0}, 1'b0, "m24_2");
    home(hsq_pkg::M_24, 16'h00B4, 1'b0, '{3'h7, 3'h5, 3'h4, 3'h6, 3'h0}, 1'b0, "m24_3");
  endtask

  task automatic t_m25;
    home(hsq_pkg::M_25, 16'h0000, 1'b0, '{3'h7, 3'h6, 3'h4, 3'h0}, 1'b0, "m25_1");
    home(hsq_pkg::M_25, 16'h006E, 1'b1, '{3'h6, 3'h4, 3'h0}, 1'b0, "m25_2");
    home(hsq_pkg::M_25, 16'h00B4, 1'b0, '{3'h7, 3'h5, 3'h6, 3'h4, 3'h0}, 1'b0, "m25_3");
  endtask

  task automatic t_m26;
    home(hsq_pkg::M_26, 16'h0000, 1'b0, '{3'h7, 3'h6, 3'h0}, 1'b0, "m26_1");
    home(hsq_pkg::M_26, 16'h006E, 1'b1, '{3'h6, 3'h0}, 1'b0, "m26_2");
  endtask

  // A second start in mid-run must not disturb the series under way.
  task automatic t_busy_start;
    home(hsq_pkg::M_24, 16'h0000, 1'b0, '{3'h7, 3'h4, 3'h6, 3'h0}, 1'b1, "restart");
  endtask

  task automatic t_reserved;
    logic [7:0] codes[2];
    codes = '{hsq_pkg::M_RSV_LO, hsq_pkg::M_RSV_HI};
    foreach (codes[i]) begin
      launch(codes[i], 16'h0000, 1'b0);
      repeat (3) @(negedge i_sys_clk);
      `CHK("reserved fault", 1'b1, o_fault)
      `CHK("reserved cmd", 3'h0, o_cmd)
      `CHK("reserved busy", 1'b0, o_busy)
    end
    $display("test reserved finished");
  endtask

  task automatic t_abort;
    launch(hsq_pkg::M_24, 16'h0000, 1'b0);
    repeat (4) @(posedge i_sys_clk);
    ce      <= 1'b0;
    i_abort <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    `CHK("frozen cmd", 3'h7, o_cmd)
    `CHK("frozen busy", 1'b1, o_busy)
    @(posedge i_sys_clk);
    ce <= 1'b1;
    @(posedge i_sys_clk);
    i_abort <= 1'b0;
    @(negedge i_sys_clk);
    `CHK("abort fault", 1'b0, o_fault)
    `CHK("abort cmd", 3'h0, o_cmd)
    `CHK("abort busy", 1'b0, o_busy)
    `CHK("abort done", 1'b0, o_done)
    $display("test abort finished");
  endtask

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    fails++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_m24();
    t_m25();
    t_m26();
    t_busy_start();
    t_reserved();
    t_abort();
    summarize();
  end
endmodule

// ===== hsq_motion_model.sv
// Behavioural axis with two origin cams and a forward limit, driven by the motion command.
`timescale 1ns/1ps

module hsq_motion_model (
  input  wire logic              i_sys_clk,
  input  wire hsq_pkg::hsq_cmd_t i_cmd,
  input  wire logic              i_load,
  input  wire logic [15:0]       i_pos,
  input  wire logic              i_decel_ok,
  output hsq_pkg::hsq_sw_t       o_sw
);
  logic [15:0] pos;
  logic [15:0] step;

  // ----------------------------------------------------------------
  // Axis position
  // ----------------------------------------------------------------
  assign step = i_cmd.high ? 16'h0004 : 16'h0001;

  always @(posedge i_sys_clk) begin
    if (i_load) begin
      pos <= i_pos;
    end else if (i_cmd.run) begin
      pos <= i_cmd.fwd ? pos + step : pos - step;
    end
  end

  // ----------------------------------------------------------------
  // Switches
  // ----------------------------------------------------------------
  // Two cams so that a second origin falling edge exists ahead of the first.
  assign o_sw.origin    = (pos >= 16'h0064 && pos <= 16'h0077) ||
                          (pos >= 16'h008C && pos <= 16'h009F);
  assign o_sw.fwd_limit = (pos >= 16'h00C8) && (pos < 16'h8000);
  assign o_sw.decel_ok  = i_decel_ok;
endmodule

// ===== hsq_pkg.sv
// Constants, command encodings and state codes for the homing sequencer.
package hsq_pkg;

  // ----------------------------------------------------------------
  // Homing method codes
  // ----------------------------------------------------------------
  localparam int         METHOD_W = 8;
  localparam logic [7:0] M_RSV_LO = 8'h0F;
  localparam logic [7:0] M_RSV_HI = 8'h10;
  localparam logic [7:0] M_24     = 8'h18;
  localparam logic [7:0] M_25     = 8'h19;
  localparam logic [7:0] M_26     = 8'h1A;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic fwd;
    logic high;
  } hsq_cmd_t;

  typedef struct packed {
    logic origin;
    logic fwd_limit;
    logic decel_ok;
  } hsq_sw_t;

  localparam hsq_cmd_t CMD_STOP     = 3'h0;
  localparam hsq_cmd_t CMD_REV_LOW  = 3'h4;
  localparam hsq_cmd_t CMD_REV_HIGH = 3'h5;
  localparam hsq_cmd_t CMD_FWD_LOW  = 3'h6;
  localparam hsq_cmd_t CMD_FWD_HIGH = 3'h7;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE    = 5'h01,
    S_FAST    = 5'h02,
    S_RETRACT = 5'h04,
    S_LOW_A   = 5'h08,
    S_LOW_B   = 5'h10
  } hsq_state_t;

endpackage
